// ===== hw/analog_die_spi_interrupt_logic.sv
// serial register slave, event flags, interrupt and wake-up logic of the analog die
//
// Behaviour
// - six interrupt sources, enables cleared by reset
// - supply low sets flag, masked interrupt
// - supply high sets flag, masked interrupt
// - supply fault forces high-side switches off
// - overtemperature sets flag, masked interrupt
// - stop mode disables supply and temperature detection
// - bus falling edge interrupts, wakes in stop
// - enabled hall current raises interrupt, wakes
// - any over-current sets flag, masked interrupt
// - masked wake events wake controller and regulator
// - frame is two bytes each way
// - output driven only while select low
// - output changes on rise, samples on fall
// - exactly sixteen sampling edges accept a frame
// - write data loads on select rising
// - read value captured at parity bit
// - first byte: direction, address, parity, spare
// - direction one reads, zero writes
// - even parity over direction and address
// - first returned byte is system status
// - run mode: enabled hall change sets flag
// - stop mode: cyclic check plus hall current
// - hall flag cleared by one or reset
// - bus flag set on fall, write-one clear
// - clear ignored while cause still present
// - mask bits gate flags, cleared by reset
// - over-current flag cleared through status register
`default_nettype none
`include "analog_die_regs.svh"
module analog_die_spi_interrupt_logic (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // serial link from the master
    input wire logic ss_n,
    input wire logic serial_clock,
    input wire logic mosi,
    output logic miso_out,
    output logic miso_oe,
    // analog detectors and pins, all asynchronous
    input wire logic supply_low_event,
    input wire logic supply_high_event,
    input wire logic overtemp_event,
    input wire logic bus_line,
    input wire logic [2:0] hall_inputs,
    input wire logic [3:0] overcurrent_in,
    input wire logic bus_current_limit,
    input wire logic autonomous_timeout_unit_wake,
    input wire logic undervoltage_reset,
    input wire logic stop_mode,
    // open-drain interrupt request, plain driven wake-up requests
    output logic irq_n_out,
    output logic irq_n_oe,
    output logic wake_mcu,
    output logic wake_main_regulator,
    // register-driven controls
    output logic [7:0] bridge_drive,
    output logic high_side_on,
    output logic [7:0] bridge_ctl,
    output logic [7:0] system_ctl,
    output logic [7:0] reset_mask,
    output logic [3:0] mux_select,
    output logic [2:0] hall_enable,
    output logic [7:0] watchdog_ctl,
    output logic [7:0] power_out
);
    // ====================
    // decoding functions

    // writable bits per offset, zero for unmapped or read-only offsets
    function automatic logic [7:0] write_mask(input logic [4:0] a);
        case (a)
            `A_BRIDGE_DRIVE: write_mask = `M_BRIDGE_DRIVE;
            `A_BRIDGE_CTL: write_mask = `M_BRIDGE_CTL;
            `A_SYS_CTL: write_mask = `M_SYS_CTL;
            `A_INT_MASK: write_mask = `M_INT_MASK;
            `A_RESET_MASK: write_mask = `M_RESET_MASK;
            `A_MUX_SEL: write_mask = `M_MUX_SEL;
            `A_HALL_EN: write_mask = `M_HALL_EN;
            `A_WDOG_CTL: write_mask = `M_WDOG_CTL;
            `A_POWER_OUT: write_mask = `M_POWER_OUT;
            default: write_mask = 8'h00;
        endcase
    endfunction

    // read value of any offset; unmapped offsets read zero
    function automatic logic [7:0] read_reg(input logic [4:0] a, input logic [15:0][7:0] cfg,
                                            input logic [7:0] flg, input logic [7:0] hall,
                                            input logic [7:0] stat);
        case (a)
            `A_INT_FLAGS: read_reg = flg;
            `A_HALL_STATE: read_reg = hall;
            `A_SYS_STATUS: read_reg = stat;
            default: read_reg = cfg[a[3:0]] & write_mask(a);
        endcase
    endfunction

    // ====================
    // state and combinational terms
    analog_die_pkg::die_state_t st_r;   // registered state
    analog_die_pkg::die_state_t st_nxt; // next state
    logic ss_fall;        // select went active
    logic ss_rise;        // select went inactive
    logic sck_rise;       // serial clock rising
    logic sck_fall;       // serial clock falling (sampling)
    logic in_stop;        // stop mode, synced
    logic low_now;        // supply low while detection runs
    logic high_now;       // supply high while detection runs
    logic temp_now;       // overtemperature while detection runs
    logic bus_fall;       // falling edge on the bus line
    logic hall_run;       // run-mode hall change
    logic hall_stop;      // stop-mode hall current during cyclic check
    logic [2:0] hall_en;  // enabled hall inputs
    logic [7:0] flags_v;  // flag register read value
    logic [7:0] status_v; // status register read value
    logic [7:0] set_v;    // flags set this cycle
    logic [7:0] clr_v;    // flags cleared this cycle
    logic [3:0] oc_clr;   // over-current flags cleared this cycle
    logic wr_ok;          // accepted write frame ends
    logic [4:0] wr_addr;  // address of the finished frame
    logic [7:0] wr_data;  // data byte of the finished frame
    logic [7:0] wr_m;     // writable bits at that address
    logic [15:0] rx_v;    // frame after this sample
    logic fault;          // supply fault forcing high sides off
    logic wake_ev;        // masked wake-up event in stop

    // ====================
    // next-state logic
    always_comb begin
        st_nxt = st_r;
        // two-stage synchronisers, then one stage of history
        st_nxt.s1 = {stop_mode, undervoltage_reset, autonomous_timeout_unit_wake, bus_current_limit,
                     overcurrent_in, overtemp_event, supply_high_event, supply_low_event,
                     hall_inputs, bus_line, mosi, serial_clock, ss_n};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // edges of the synced link pins
        ss_fall = st_r.s3[`SY_SS] & ~st_r.s2[`SY_SS];
        ss_rise = ~st_r.s3[`SY_SS] & st_r.s2[`SY_SS];
        sck_rise = ~st_r.s3[`SY_SCK] & st_r.s2[`SY_SCK];
        sck_fall = st_r.s3[`SY_SCK] & ~st_r.s2[`SY_SCK];
        // detectors are switched off in stop mode
        in_stop = st_r.s2[`SY_STOP];
        low_now = st_r.s2[`SY_LOW] & ~in_stop;
        high_now = st_r.s2[`SY_HIGH] & ~in_stop;
        temp_now = st_r.s2[`SY_TEMP] & ~in_stop;
        bus_fall = st_r.s3[`SY_BUS] & ~st_r.s2[`SY_BUS];
        // hall events depend on the mode
        hall_en = st_r.cfg[`A_HALL_EN][2:0];
        hall_run = ~in_stop & (|((st_r.s2[`SY_HALL +: 3] ^ st_r.s3[`SY_HALL +: 3]) & hall_en));
        hall_stop = in_stop & st_r.cfg[`A_WDOG_CTL][`B_CYCLIC] & (|(st_r.s2[`SY_HALL +: 3] & hall_en));
        // read views of flags and status
        flags_v = {1'b0, st_r.flags[6:2], |st_r.overcurrent_flag, 1'b0};
        status_v = {st_r.overcurrent_flag[3], st_r.s2[`SY_LINCL], st_r.overcurrent_flag[2], st_r.overcurrent_flag[1],
                    st_r.flags[`B_LOW], st_r.flags[`B_HIGH], st_r.overcurrent_flag[0], st_r.flags[`B_TEMP]};
        // write commit on select release: count, direction and parity checked
        wr_addr = st_r.rx[14:10];
        wr_data = st_r.rx[7:0];
        wr_m = write_mask(wr_addr);
        wr_ok = ss_rise & (st_r.phase == analog_die_pkg::PH_ACTIVE)
              & (st_r.fcnt == `FRAME_BITS)
              & ~st_r.rx[15]
              & ~(^st_r.rx[15:9]);
        clr_v = 8'h00;
        oc_clr = 4'h0;
        if (wr_ok) begin
            if (wr_addr == `A_INT_FLAGS) begin
                // write one clears, zero leaves alone
                clr_v = wr_data & `M_FLAG_CLEAR;
            end else if (wr_addr == `A_SYS_STATUS) begin
                // over-current and shared flags cleared here
                oc_clr = {wr_data[7], wr_data[5], wr_data[4], wr_data[1]};
                clr_v[`B_LOW] = wr_data[3];
                clr_v[`B_HIGH] = wr_data[2];
                clr_v[`B_TEMP] = wr_data[0];
            end else begin
                // stored registers keep their read-only bits
                st_nxt.cfg[wr_addr[3:0]] = (st_r.cfg[wr_addr[3:0]] & ~wr_m) | (wr_data & wr_m);
            end
        end
        // event flags: set wins over clear, so a present cause cannot be cleared
        set_v = 8'h00;
        set_v[`B_HALL] = hall_run | hall_stop;
        set_v[`B_BUS] = bus_fall;
        set_v[`B_TEMP] = temp_now;
        set_v[`B_LOW] = low_now;
        set_v[`B_HIGH] = high_now;
        st_nxt.flags = ((st_r.flags & ~clr_v) | set_v) & `M_FLAG_CLEAR;
        st_nxt.overcurrent_flag = (st_r.overcurrent_flag & ~oc_clr) | st_r.s2[`SY_OC +: 4];
        // interrupt request: any flag with its mask bit
        st_nxt.irq = |(flags_v & st_r.cfg[`A_INT_MASK]);
        // wake-up in stop mode on masked events, dropped when stop ends
        wake_ev = (bus_fall & st_r.cfg[`A_INT_MASK][`B_BUS])
                | (st_r.s2[`SY_WAKE] & st_r.cfg[`A_WDOG_CTL][`B_WDOG_IE])
                | (hall_stop & st_r.cfg[`A_INT_MASK][`B_HALL])
                | (st_r.s2[`SY_UVR] & st_r.cfg[`A_INT_MASK][`B_LOW]);
        st_nxt.wake = in_stop & (st_r.wake | wake_ev);
        // supply fault forces bridge high sides and high-side driver off
        fault = low_now | high_now;
        st_nxt.drive = st_r.cfg[`A_BRIDGE_DRIVE] & ~(fault ? `HS_BITS : 8'h00);
        st_nxt.hs_on = st_r.cfg[`A_POWER_OUT][`B_HS_ON] & ~fault;
        // serial frame engine
        rx_v = {st_r.rx[14:0], st_r.s2[`SY_MOSI]};
        unique case (st_r.phase)
            analog_die_pkg::PH_IDLE: begin
                // select falls: status snapshot prepared, output driven low
                if (ss_fall) begin
                    st_nxt.phase = analog_die_pkg::PH_ACTIVE;
                    st_nxt.rcnt = 5'h00;
                    st_nxt.fcnt = 5'h00;
                    st_nxt.rx = 16'h0000;
                    st_nxt.snap = status_v;
                    st_nxt.miso = 1'b0;
                end
            end
            analog_die_pkg::PH_ACTIVE: begin
                if (ss_rise) begin
                    st_nxt.phase = analog_die_pkg::PH_IDLE;
                end else begin
                    // output changes on rising edges: status byte, then data byte
                    if (sck_rise) begin
                        if (st_r.rcnt < `STATUS_BITS) begin
                            st_nxt.miso = st_r.snap[~st_r.rcnt[2:0]];
                        end else if (st_r.rcnt < `FRAME_BITS) begin
                            st_nxt.miso = st_r.rdata[~st_r.rcnt[2:0]];
                        end else begin
                            st_nxt.miso = 1'b0;
                        end
                        if (st_r.rcnt != `CNT_MAX) begin
                            st_nxt.rcnt = st_r.rcnt + 5'h01;
                        end
                    end
                    // master data sampled on falling edges
                    if (sck_fall) begin
                        st_nxt.rx = rx_v;
                        if (st_r.fcnt != `CNT_MAX) begin
                            st_nxt.fcnt = st_r.fcnt + 5'h01;
                        end
                        // parity bit arriving: latch the selected register
                        if (st_r.fcnt == `PARITY_SAMPLE) begin
                            st_nxt.rdata = read_reg(rx_v[5:1], st_r.cfg, flags_v,
                                                    {5'h00, st_r.s2[`SY_HALL +: 3]}, status_v);
                        end
                    end
                end
            end
        endcase
    end

    // ====================
    // state register, synchronous reset clears everything
    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ====================
    // outputs from flip-flops, except the interrupt pin data, which is tied low
    assign miso_out = st_r.miso;
    assign miso_oe = (st_r.phase == analog_die_pkg::PH_ACTIVE);
    assign irq_n_out = 1'b0;
    assign irq_n_oe = st_r.irq;
    assign wake_mcu = st_r.wake;
    assign wake_main_regulator = st_r.wake;
    assign bridge_drive = st_r.drive;
    assign high_side_on = st_r.hs_on;
    assign bridge_ctl = st_r.cfg[`A_BRIDGE_CTL];
    assign system_ctl = st_r.cfg[`A_SYS_CTL];
    assign reset_mask = st_r.cfg[`A_RESET_MASK];
    assign mux_select = st_r.cfg[`A_MUX_SEL][3:0];
    assign hall_enable = st_r.cfg[`A_HALL_EN][2:0];
    assign watchdog_ctl = st_r.cfg[`A_WDOG_CTL];
    assign power_out = st_r.cfg[`A_POWER_OUT];

    // ====================
    // assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_MASK_RESET: assert property (disable iff (1'b0) $fell(rst) |-> st_r.cfg[`A_INT_MASK] == 8'h00)
        else $error("mask not cleared by reset");
    AST_LOW_FLAG: assert property (st_r.s2[`SY_LOW] && !st_r.s2[`SY_STOP] |=> st_r.flags[`B_LOW])
        else $error("supply low did not set its flag");
    AST_HIGH_FLAG: assert property (st_r.s2[`SY_HIGH] && !st_r.s2[`SY_STOP] |=> st_r.flags[`B_HIGH])
        else $error("supply high did not set its flag");
    AST_HS_FORCE: assert property (low_now || high_now |=> ((bridge_drive & `HS_BITS) == 8'h00) && !high_side_on)
        else $error("high sides not forced off on supply fault");
    AST_TEMP_FLAG: assert property (temp_now |=> st_r.flags[`B_TEMP])
        else $error("overtemperature did not set its flag");
    AST_STOP_QUIET: assert property (in_stop && !st_r.flags[`B_LOW] |=> !st_r.flags[`B_LOW])
        else $error("low flag set during stop mode");
    AST_WAKE: assert property (in_stop && bus_fall && st_r.cfg[`A_INT_MASK][`B_BUS] |=> wake_mcu && wake_main_regulator)
        else $error("masked bus edge did not wake in stop");
    AST_HALL_RUN: assert property (hall_run |=> st_r.flags[`B_HALL])
        else $error("hall change did not set flag");
    AST_BUS_FLAG: assert property (bus_fall |=> st_r.flags[`B_BUS] [*2])
        else $error("bus edge flag not set and held");
    AST_IRQ: assert property (|(flags_v & st_r.cfg[`A_INT_MASK]) |=> irq_n_oe)
        else $error("masked flag did not pull interrupt low");
    AST_IRQ_MASKED: assert property (st_r.cfg[`A_INT_MASK] == 8'h00 |=> !irq_n_oe)
        else $error("interrupt raised with all masks clear");
    AST_MISO_Z: assert property (ss_rise |=> !miso_oe)
        else $error("serial output still driven after select release");
    AST_BAD_FRAME: assert property (ss_rise && st_r.fcnt != `FRAME_BITS |=> $stable(st_r.cfg))
        else $error("miscounted frame changed a register");

    CV_WRITE: cover property (wr_ok);
    CV_READ: cover property (ss_rise && st_r.fcnt == `FRAME_BITS && st_r.rx[15]);
    CV_WAKE: cover property ($rose(wake_mcu));
    CV_IRQ: cover property ($rose(irq_n_oe));
endmodule // analog_die_spi_interrupt_logic
`default_nettype wire

// ===== hw/analog_die_regs.svh
// register map, field positions, sync indices and frame counts of the analog die logic
`ifndef ANALOG_DIE_REGS_SVH
`define ANALOG_DIE_REGS_SVH
// ====================
// register offsets
`define A_BRIDGE_DRIVE 5'h01
`define A_BRIDGE_CTL 5'h02
`define A_SYS_CTL 5'h03
`define A_INT_MASK 5'h04
`define A_INT_FLAGS 5'h05
`define A_RESET_MASK 5'h06
`define A_MUX_SEL 5'h07
`define A_HALL_EN 5'h08
`define A_HALL_STATE 5'h09
`define A_WDOG_CTL 5'h0a
`define A_POWER_OUT 5'h0b
`define A_SYS_STATUS 5'h0c
// ====================
// writable bits of each stored register, and reset value
`define M_BRIDGE_DRIVE 8'hff
`define M_BRIDGE_CTL 8'hc7
`define M_SYS_CTL 8'he1
`define M_INT_MASK 8'h7e
`define M_RESET_MASK 8'h83
`define M_MUX_SEL 8'h0f
`define M_HALL_EN 8'h07
`define M_WDOG_CTL 8'h3f
`define M_POWER_OUT 8'h3f
`define M_FLAG_CLEAR 8'h7c
`define RST_BYTE 8'h00
// ====================
// flag and mask bit positions, shared by both registers
`define B_HALL 6
`define B_BUS 5
`define B_TEMP 4
`define B_LOW 3
`define B_HIGH 2
`define B_OC 1
// control bit positions
`define B_CYCLIC 2
`define B_WDOG_IE 3
`define B_HS_ON 0
`define HS_BITS 8'haa
// ====================
// synchroniser vector layout
`define SY_SS 0
`define SY_SCK 1
`define SY_MOSI 2
`define SY_BUS 3
`define SY_HALL 4
`define SY_LOW 7
`define SY_HIGH 8
`define SY_TEMP 9
`define SY_OC 10
`define SY_LINCL 14
`define SY_WAKE 15
`define SY_UVR 16
`define SY_STOP 17
`define SYNC_W 18
// ====================
// frame counts
`define FRAME_BITS 5'h10
`define PARITY_SAMPLE 5'h06
`define STATUS_BITS 5'h08
`define CNT_MAX 5'h1f
`endif

// ===== hw/analog_die_pkg.sv
// types of the analog die serial and interrupt logic
`default_nettype none
`include "analog_die_regs.svh"
package analog_die_pkg;
    // serial frame phase
    typedef enum logic {
        PH_IDLE = 1'b0,
        PH_ACTIVE = 1'b1
    } spi_phase_t;
    // whole state of the block
    typedef struct packed {
        logic [`SYNC_W-1:0] s1;     // first sync stage
        logic [`SYNC_W-1:0] s2;     // second sync stage
        logic [`SYNC_W-1:0] s3;     // previous synced value, for edges
        spi_phase_t phase;          // frame phase
        logic [4:0] rcnt;           // rising serial clock edges
        logic [4:0] fcnt;           // falling (sampling) edges
        logic [15:0] rx;            // received frame
        logic [7:0] snap;           // status byte of this frame
        logic [7:0] rdata;          // selected register read value
        logic miso;                 // serial output bit
        logic [15:0][7:0] cfg;      // stored registers by offset
        logic [7:0] flags;          // event flags, bits 6..2
        logic [3:0] overcurrent_flag;            // over-current flags
        logic irq;                  // interrupt request
        logic wake;                 // wake-up request
        logic [7:0] drive;          // bridge drive after protection
        logic hs_on;                // high-side driver after protection
    } die_state_t;
endpackage
`default_nettype wire

// ===== tb/spi_master_model.sv
// serial master model driving select, clock and data toward the analog die
`default_nettype none
module spi_master_model (
    // system clock
    input wire logic clock,
    // serial link
    output logic ss_n,
    output logic serial_clock,
    output logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // reply bits seen on the slave output
    logic [15:0] rx_r;
    // idle link: select high, clock low
    initial begin
        ss_n = 1'b1;
        serial_clock = 1'b0;
        mosi = 1'b0;
        rx_r = 16'h0000;
    end
    // one frame of tx, msb first, with the given count of sampling edges
    task automatic frame(input logic [15:0] tx, input int edges);
        ss_n <= 1'b0;
        repeat (8) @(posedge clock);
        // half periods of 62.5 ns give a 125 ns serial clock; every fourth edge lands on a system clock edge, the others fall between
        for (int i = 0; i < edges; i++) begin
            serial_clock <= 1'b1;
            mosi <= tx[15 - (i % 16)];
            #62.5;
            // undriven output is read as the inverse, so a lost drive shows
            rx_r <= {rx_r[14:0], miso_oe ? miso_out : ~miso_out};
            serial_clock <= 1'b0;
            #62.5;
        end
        repeat (8) @(posedge clock);
        ss_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge clock);
    endtask
endmodule // spi_master_model
`default_nettype wire

// ===== tb/analog_die_spi_interrupt_logic_test.sv
// self-checking bench of the analog die serial and interrupt logic
`default_nettype none
`include "analog_die_regs.svh"
module analog_die_spi_interrupt_logic_test;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // design signals
    logic clock, rst, ss_n, serial_clock, mosi, miso_out, miso_oe, irq_n_out, irq_n_oe;
    logic wake_mcu, wake_main_regulator, high_side_on, stop_mode, bus_line, supply_low_event;
    logic supply_high_event, overtemp_event, bus_current_limit, autonomous_timeout_unit_wake, undervoltage_reset;
    logic [2:0] hall_inputs;
    logic [3:0] overcurrent_in;
    logic [7:0] bridge_drive;
    logic [7:0] bridge_ctl, system_ctl, reset_mask, watchdog_ctl, power_out;
    logic [3:0] mux_select;
    logic [2:0] hall_enable;
    int fail_count, samples_checked;
    // writable registers and their masks
    logic [4:0] addr_t [9] = '{`A_BRIDGE_DRIVE, `A_BRIDGE_CTL, `A_SYS_CTL, `A_INT_MASK, `A_RESET_MASK,
                               `A_MUX_SEL, `A_HALL_EN, `A_WDOG_CTL, `A_POWER_OUT};
    logic [7:0] mask_t [9] = '{`M_BRIDGE_DRIVE, `M_BRIDGE_CTL, `M_SYS_CTL, `M_INT_MASK, `M_RESET_MASK,
                               `M_MUX_SEL, `M_HALL_EN, `M_WDOG_CTL, `M_POWER_OUT};
    // 4 ns system clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    analog_die_spi_interrupt_logic u_analog_die_spi_interrupt_logic (
        .clock(clock), .rst(rst), .ss_n(ss_n), .serial_clock(serial_clock), .mosi(mosi),
        .miso_out(miso_out), .miso_oe(miso_oe), .supply_low_event(supply_low_event),
        .supply_high_event(supply_high_event), .overtemp_event(overtemp_event), .bus_line(bus_line),
        .hall_inputs(hall_inputs), .overcurrent_in(overcurrent_in), .bus_current_limit(bus_current_limit),
        .autonomous_timeout_unit_wake(autonomous_timeout_unit_wake), .undervoltage_reset(undervoltage_reset),
        .stop_mode(stop_mode), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .wake_mcu(wake_mcu),
        .wake_main_regulator(wake_main_regulator), .bridge_drive(bridge_drive), .high_side_on(high_side_on),
        .bridge_ctl(bridge_ctl), .system_ctl(system_ctl), .reset_mask(reset_mask), .mux_select(mux_select),
        .hall_enable(hall_enable), .watchdog_ctl(watchdog_ctl), .power_out(power_out)
    );
    spi_master_model u_spi_master_model (
        .clock(clock), .ss_n(ss_n), .serial_clock(serial_clock), .mosi(mosi),
        .miso_out(miso_out), .miso_oe(miso_oe)
    );
    // ==========
    // shared tasks
    // prints the counts and the verdict, then ends the run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // compares one byte and counts it
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    // register-driven output of table entry k; the interrupt mask has no output of its own
    function automatic logic [7:0] port_val(input int k);
        logic [7:0] v [9];
        v = '{bridge_drive, bridge_ctl, system_ctl, 8'h00, reset_mask, {4'h0, mux_select},
              {5'h00, hall_enable}, watchdog_ctl, power_out};
        return v[k];
    endfunction
    // one frame: direction, address, parity (flip spoils it), spare, data
    task automatic xfer(input logic rw, input logic [4:0] a, input logic [7:0] d, input int edges,
                        input logic flip, output logic [15:0] r);
        u_spi_master_model.frame({rw, a, ^{rw, a} ^ flip, 1'b0, d}, edges);
        r = u_spi_master_model.rx_r;
    endtask
    // plain write
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [15:0] r;
        xfer(1'b0, a, d, 16, 1'b0, r);
    endtask
    // read and compare the data byte
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        logic [15:0] r;
        xfer(1'b1, a, 8'($urandom), 16, 1'b0, r);
        chk("register", exp, r[7:0]);
    endtask
    // bounded wait for irq (sel 0) or wake (sel 1) to reach a level
    task automatic wait_bit(input int sel, input logic exp);
        int n;
        n = 0;
        while ((sel == 0 ? irq_n_oe : wake_mcu) !== exp && n < 100) begin
            @(posedge clock);
            n++;
        end
        chk("request", {7'h00, exp}, {7'h00, sel == 0 ? irq_n_oe : wake_mcu});
        // a limit that ran out with the level still wrong ends the run as a failure
        if ((sel == 0 ? irq_n_oe : wake_mcu) !== exp) begin
            wrap_up();
        end
    endtask
    // ==========
    // main sequence
    initial begin
        logic [15:0] r;
        logic [7:0] d1, d2;
        fail_count = 0;
        samples_checked = 0;
        {rst, bus_line} = 2'b11;
        {supply_low_event, supply_high_event, overtemp_event, bus_current_limit, stop_mode} = 5'h00;
        {autonomous_timeout_unit_wake, undervoltage_reset, hall_inputs, overcurrent_in} = 9'h000;
        void'($urandom(21));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        // reset values and status byte of every writable register
        for (int k = 0; k < 9; k++) begin
            xfer(1'b1, addr_t[k], 8'h00, 16, 1'b0, r);
            chk("reset value", `RST_BYTE, r[7:0]);
            chk("status byte", 8'h00, r[15:8]);
        end
        $display("test reset values done");
        // random writes, prior contents returned, read back
        for (int k = 0; k < 9; k++) begin
            d1 = 8'($urandom);
            d2 = 8'($urandom);
            wr(addr_t[k], d1);
            xfer(1'b0, addr_t[k], d2, 16, 1'b0, r);
            chk("prior data", d1 & mask_t[k], r[7:0]);
            rd(addr_t[k], d2 & mask_t[k]);
            if (k != 3) begin
                chk("register output", d2 & mask_t[k], port_val(k));
            end
        end
        $display("test random registers done");
        // bad parity and short frame are discarded
        wr(`A_INT_MASK, 8'h00);
        xfer(1'b0, `A_INT_MASK, 8'h7e, 16, 1'b1, r);
        rd(`A_INT_MASK, 8'h00);
        xfer(1'b0, `A_INT_MASK, 8'h7e, 15, 1'b0, r);
        rd(`A_INT_MASK, 8'h00);
        wr(`A_INT_MASK, 8'h7e);
        $display("test refused frames done");
        // supply low flag, interrupt, blocked and real clear
        supply_low_event <= 1'b1;
        wait_bit(0, 1'b1);
        chk("interrupt pin data", 8'h00, {7'h00, irq_n_out});
        xfer(1'b1, `A_INT_FLAGS, 8'h00, 16, 1'b0, r);
        chk("status low", 8'h08, r[15:8] & 8'h08);
        wr(`A_INT_FLAGS, 8'h08);
        rd(`A_INT_FLAGS, 8'h08);
        supply_low_event <= 1'b0;
        wr(`A_INT_FLAGS, 8'h08);
        rd(`A_INT_FLAGS, 8'h00);
        wait_bit(0, 1'b0);
        $display("test supply low done");
        // supply high forces high-side switches off
        wr(`A_BRIDGE_DRIVE, 8'hff);
        wr(`A_POWER_OUT, 8'h01);
        supply_high_event <= 1'b1;
        wait_bit(0, 1'b1);
        chk("bridge drive", 8'h55, bridge_drive);
        chk("high side", 8'h00, {7'h00, high_side_on});
        rd(`A_INT_FLAGS, 8'h04);
        supply_high_event <= 1'b0;
        wr(`A_INT_FLAGS, 8'h04);
        chk("bridge drive", 8'hff, bridge_drive);
        chk("high side", 8'h01, {7'h00, high_side_on});
        $display("test supply high done");
        // over-current flag is cleared only through the status register
        overcurrent_in <= 4'h1;
        wait_bit(0, 1'b1);
        overcurrent_in <= 4'h0;
        wr(`A_INT_FLAGS, 8'h02);
        rd(`A_INT_FLAGS, 8'h02);
        wr(`A_SYS_STATUS, 8'h02);
        rd(`A_INT_FLAGS, 8'h00);
        $display("test over-current done");
        // stop mode: detectors off, bus falling edge wakes
        stop_mode <= 1'b1;
        supply_low_event <= 1'b1;
        rd(`A_INT_FLAGS, 8'h00);
        bus_line <= 1'b0;
        wait_bit(1, 1'b1);
        chk("regulator wake", 8'h01, {7'h00, wake_main_regulator});
        rd(`A_INT_FLAGS, 8'h20);
        supply_low_event <= 1'b0;
        stop_mode <= 1'b0;
        bus_line <= 1'b1;
        wait_bit(1, 1'b0);
        wr(`A_INT_FLAGS, 8'h00);
        rd(`A_INT_FLAGS, 8'h20);
        wr(`A_INT_FLAGS, 8'h20);
        rd(`A_INT_FLAGS, 8'h00);
        $display("test stop mode done");
        // run mode hall change sets flag, write-one clear
        wr(`A_HALL_EN, 8'h01);
        hall_inputs <= 3'h1;
        wait_bit(0, 1'b1);
        wr(`A_INT_FLAGS, 8'h00);
        rd(`A_INT_FLAGS, 8'h40);
        wr(`A_INT_FLAGS, 8'h40);
        rd(`A_INT_FLAGS, 8'h00);
        $display("test hall done");
        wrap_up();
    end
endmodule // analog_die_spi_interrupt_logic_test
`default_nettype wire
